/* File: video_pins_defines.svh */
// Purpose: Shared constants for the video decoder pin interface.
// Assumes: 32-bit classic Wishbone, word-aligned registers, 100 MHz clk_i.
// Notes: Offsets are byte addresses; fields are bit positions.
`ifndef VIDEO_PINS_DEFINES_SVH
`define VIDEO_PINS_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_VBLANK 8'h04
`define REG_NCO 8'h08
`define REG_PICT0 8'h0C
`define REG_PICT1 8'h10
`define REG_STATUS 8'h14
`define REG_VBI 8'h18
`define REG_CHROMA 8'h1C

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CTRL_EMBEDDED 0
`define CTRL_SCLK_2X 1
`define CTRL_ACTIVE_VIDEO_FLAG_OE 2
`define CTRL_FIELD_VLOCK 3
`define CTRL_VS_LO 4
`define CTRL_VS_HI 5
`define CTRL_GP_LO 6
`define CTRL_GP_HI 7
`define CTRL_GP_LEVEL 8
`define CTRL_CHROMA_RTC 9
`define CTRL_PIN_CHROMA 10
`define CTRL_RESET 32'h0000_0007

// ------------------------------------------------------------
// Reset values and address choices
// ------------------------------------------------------------
`define VBLANK_RESET 32'h0015_0001
`define ADDR_STRAP_HIGH 8'hBA
`define ADDR_STRAP_LOW 8'hB8

// ------------------------------------------------------------
// Timing: sample rate against the system clock, in kHz
// ------------------------------------------------------------
`define CLK_RATE_KHZ 100000
`define SAMPLE_RATE_KHZ 27000
`define NCO_MOD (`CLK_RATE_KHZ)
`define NCO_NOMINAL (2 * `SAMPLE_RATE_KHZ)

`endif

/* File: video_pins_pkg.sv */
// Purpose: Types for the video decoder pin interface.
// Assumes: Constants come from video_pins_defines.svh.
// Notes: Line phases use Gray codes along the line.
package video_pins_pkg;

   // Position of the byte stream within one line
   typedef enum logic [1:0] {
      PH_EAV = 2'b00,
      PH_BLANK = 2'b01,
      PH_SAV = 2'b11,
      PH_ACTIVE = 2'b10
   } line_phase_t;

   // Function of the general-purpose pin
   typedef enum logic [1:0] {
      GP_OUTPUT = 2'b00,
      GP_VBLANK = 2'b01,
      GP_SYNC_LOCK = 2'b10,
      GP_IRQ = 2'b11
   } gp_mode_t;

   // Function of the vertical sync pin
   typedef enum logic [1:0] {
      VS_SYNC = 2'b00,
      VS_LINE_FLAG = 2'b01,
      VS_HLOCK = 2'b10,
      VS_SPARE = 2'b11
   } vs_mode_t;

endpackage

/* File: video_pin_interface.sv */
// Purpose: Output formatter and pin control of a video decoder.
// Assumes: Video bytes and lock levels arrive on clk_i; pins are async.
// Notes: One clk_i, ce_i freezes all state.
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "video_pins_defines.svh"

module video_pin_interface #(
   parameter int LINE_BYTES = 1716,
   parameter int ACTIVE_BYTES = 1440,
   parameter int FRAME_LINES = 525,
   parameter int VSYNC_LINES = 3,
   parameter int HSYNC_BYTES = 128
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Decoded video and lock levels from the core, same clock
   input wire logic [7:0] video_in_i,
   input wire logic h_lock_i,
   input wire logic v_lock_i,
   input wire logic irq_source_i,
   // Asynchronous pins
   input wire logic power_down_n_i,
   input wire logic reset_n_i,
   input wire logic video_out_msb_i,
   input wire logic general_purpose_pin_i,
   // Output pins
   output logic [6:0] video_out_bus_o,
   output logic video_out_msb_o,
   output logic video_out_msb_oe_o,
   output logic sclk_o,
   output logic active_video_flag_o,
   output logic active_video_flag_oe_o,
   output logic hsync_o,
   output logic vsync_o,
   output logic field_pin_o,
   output logic general_purpose_pin_o,
   output logic general_purpose_pin_oe_o
);
   import video_pins_pkg::*;

   initial begin
      if (ACTIVE_BYTES + 8 > LINE_BYTES || LINE_BYTES > 4095 || FRAME_LINES > 1023 ||
          FRAME_LINES < 4 || HSYNC_BYTES < 1 || HSYNC_BYTES >= LINE_BYTES - ACTIVE_BYTES) begin
         $error("video_pin_interface: unsupported line geometry");
      end
   end

   localparam logic [11:0] LINE_LAST = 12'(LINE_BYTES - 1);
   localparam logic [11:0] SAV_START = 12'(LINE_BYTES - ACTIVE_BYTES - 4);
   localparam logic [11:0] ACT_START = 12'(LINE_BYTES - ACTIVE_BYTES);
   localparam logic [11:0] HS_BYTES = 12'(HSYNC_BYTES);
   localparam logic [9:0] FRAME_LAST = 10'(FRAME_LINES - 1);
   localparam logic [9:0] FIELD_SPLIT = 10'(FRAME_LINES / 2);
   localparam logic [9:0] VS_LINES = 10'(VSYNC_LINES);
   localparam logic [16:0] NCO_LIMIT = 17'(`NCO_MOD);
   localparam logic [15:0] NCO_NOM = 16'(`NCO_NOMINAL);

   // ----------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------
   logic [3:0] pin_meta; // First stage, read only by pin_sync
   logic [3:0] pin_sync; // pdn, rst_n, strap, gp in

   // Two flip-flops on every asynchronous input
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         pin_meta <= {general_purpose_pin_i, video_out_msb_i, reset_n_i, power_down_n_i};
         pin_sync <= pin_meta;
      end
   end

   logic pdn_active; // Standby requested
   logic soft_reset; // Register defaults requested
   assign pdn_active = !pin_sync[0];
   assign soft_reset = rst_i || (!pin_sync[1] && pin_sync[0]);

   // ----------------------------------------------------------
   // Registers
   // ----------------------------------------------------------
   logic [31:0] ctrl; // Mode control
   logic [31:0] vblank_cfg; // Blank start [9:0], end [25:16]
   logic [15:0] nco_inc; // Sample rate trim
   logic [31:0] pict0; // Hue, contrast, brightness, saturation
   logic [7:0] pict1; // Sharpness
   logic [23:0] chroma_word; // Colour loop word sent serially
   logic bus_hit; // Request in its first cycle
   assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // Merge write data with the byte enables
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Register writes; power-down keeps every value
   always_ff @(posedge clk_i) begin
      if (soft_reset) begin
         ctrl <= `CTRL_RESET;
         vblank_cfg <= `VBLANK_RESET;
         nco_inc <= NCO_NOM;
         pict0 <= 32'h0080_8000;
         pict1 <= 8'h00;
         chroma_word <= 24'h00_0000;
      end else if (ce_i && bus_hit && wb_we_i && !pdn_active) begin
         case (wb_adr_i)
            `REG_CTRL: ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
            `REG_VBLANK: vblank_cfg <= merge(vblank_cfg, wb_dat_i, wb_sel_i);
            `REG_NCO: nco_inc <= 16'(merge({16'h0000, nco_inc}, wb_dat_i, wb_sel_i));
            `REG_PICT0: pict0 <= merge(pict0, wb_dat_i, wb_sel_i);
            `REG_PICT1: pict1 <= 8'(merge({24'h00_0000, pict1}, wb_dat_i, wb_sel_i));
            `REG_CHROMA: chroma_word <= 24'(merge({8'h00, chroma_word}, wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------
   // Address strap
   // ----------------------------------------------------------
   logic strap_done; // Strap caught, MSB pin may drive
   logic [7:0] serial_addr; // Selected control address

   // Catch the strap in the first cycle after reset release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_done <= 1'b0;
         serial_addr <= `ADDR_STRAP_LOW;
      end else if (ce_i && !strap_done) begin
         strap_done <= 1'b1;
         serial_addr <= pin_sync[2] ? `ADDR_STRAP_HIGH : `ADDR_STRAP_LOW;
      end
   end

   // ----------------------------------------------------------
   // Sample clock NCO and output clock
   // ----------------------------------------------------------
   gp_mode_t gp_mode;
   vs_mode_t vs_mode;
   logic force_nominal; // Sync lock input asserted
   logic [15:0] step; // Increment in use
   logic [16:0] nco_acc; // Phase accumulator
   logic [17:0] nco_sum; // Next phase before wrap
   logic half_tick; // One output clock edge due in 2x mode
   logic byte_tick; // One output byte due
   logic half_phase; // Alternates half ticks
   assign gp_mode = gp_mode_t'(ctrl[`CTRL_GP_HI:`CTRL_GP_LO]);
   assign vs_mode = vs_mode_t'(ctrl[`CTRL_VS_HI:`CTRL_VS_LO]);
   assign force_nominal = (gp_mode == GP_SYNC_LOCK) && pin_sync[3];
   assign step = force_nominal ? NCO_NOM : nco_inc;
   assign nco_sum = {1'b0, nco_acc} + {2'b00, step};
   assign half_tick = (nco_sum >= {1'b0, NCO_LIMIT}) && !pdn_active;
   assign byte_tick = half_tick && half_phase;

   // Accumulate the sample rate against clk_i
   always_ff @(posedge clk_i) begin
      if (soft_reset) begin
         nco_acc <= 17'h0_0000;
         half_phase <= 1'b0;
      end else if (ce_i && !pdn_active) begin
         nco_acc <= half_tick ? 17'(nco_sum - {1'b0, NCO_LIMIT}) : 17'(nco_sum);
         if (half_tick) begin
            half_phase <= !half_phase;
         end
      end
   end

   // Output clock: a byte per cycle in 2x, a pixel per cycle in 1x
   always_ff @(posedge clk_i) begin
      if (soft_reset) begin
         sclk_o <= 1'b0;
      end else if (ce_i) begin
         if (ctrl[`CTRL_SCLK_2X] ? half_tick : byte_tick) begin
            sclk_o <= !sclk_o;
         end
      end
   end

   // ----------------------------------------------------------
   // Line and frame counters
   // ----------------------------------------------------------
   logic [11:0] hcount; // Byte within line
   logic [9:0] vcount; // Line within frame
   logic line_inverted; // Alternating line phase

   // Advance one byte per byte tick; halt in standby
   always_ff @(posedge clk_i) begin
      if (soft_reset) begin
         hcount <= 12'h000;
         vcount <= 10'h000;
         line_inverted <= 1'b0;
      end else if (ce_i && byte_tick) begin
         if (hcount == LINE_LAST) begin
            hcount <= 12'h000;
            line_inverted <= !line_inverted;
            vcount <= (vcount == FRAME_LAST) ? 10'h000 : 10'(vcount + 10'h001);
         end else begin
            hcount <= 12'(hcount + 12'h001);
         end
      end
   end

   // Phase of a byte position, used by the formatter and the flags
   function automatic line_phase_t phase_of(input logic [11:0] h);
      if (h < 12'h004) begin
         return PH_EAV;
      end else if (h < SAV_START) begin
         return PH_BLANK;
      end else if (h < ACT_START) begin
         return PH_SAV;
      end
      return PH_ACTIVE;
   endfunction

   line_phase_t phase;
   logic odd_field; // First half of the frame
   logic in_vblank; // Programmed blank lines
   logic in_vsync; // Vertical sync lines at field start
   logic hsync_now; // Discrete sync window
   assign phase = phase_of(hcount);
   assign odd_field = vcount < FIELD_SPLIT;
   assign in_vblank = (vcount >= vblank_cfg[9:0]) && (vcount < vblank_cfg[25:16]);
   assign in_vsync = (vcount < VS_LINES) ||
                     ((vcount >= FIELD_SPLIT) && (vcount < 10'(FIELD_SPLIT + VS_LINES)));
   assign hsync_now = hcount < HS_BYTES;

   // ----------------------------------------------------------
   // Byte formatter
   // ----------------------------------------------------------
   logic [7:0] sync_code; // Timing reference word
   logic [7:0] next_byte; // Byte for the bus
   logic is_eav; // Code marks end of active
   assign is_eav = (phase == PH_EAV);
   assign sync_code = {1'b1, !odd_field, in_vblank, is_eav, in_vblank ^ is_eav,
                       !odd_field ^ is_eav, !odd_field ^ in_vblank,
                       !odd_field ^ in_vblank ^ is_eav};

   // Choose codes, blanking levels or live video
   always_comb begin
      next_byte = hcount[0] ? 8'h10 : 8'h80;
      case (phase)
         PH_EAV, PH_SAV: begin
            if (ctrl[`CTRL_EMBEDDED]) begin
               case (hcount[1:0])
                  2'b00: next_byte = 8'hFF;
                  2'b11: next_byte = sync_code;
                  default: next_byte = 8'h00;
               endcase
            end
         end
         PH_ACTIVE: begin
            if (!in_vblank) begin
               next_byte = video_in_i;
            end
         end
         default: ;
      endcase
   end

   // Drive the video bus; MSB pin stays released until the strap is in
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         video_out_bus_o <= 7'h00;
         video_out_msb_o <= 1'b0;
         video_out_msb_oe_o <= 1'b0;
      end else if (ce_i) begin
         video_out_msb_oe_o <= strap_done && !pdn_active;
         if (byte_tick) begin
            video_out_bus_o <= next_byte[6:0];
            video_out_msb_o <= next_byte[7];
         end
      end
   end

   // ----------------------------------------------------------
   // Timing flags
   // ----------------------------------------------------------
   // Active flag, hsync, vertical pin; these keep running in blank lines
   always_ff @(posedge clk_i) begin
      if (soft_reset) begin
         active_video_flag_o <= 1'b0;
         active_video_flag_oe_o <= 1'b0;
         hsync_o <= 1'b0;
         vsync_o <= 1'b0;
      end else if (ce_i) begin
         active_video_flag_oe_o <= ctrl[`CTRL_ACTIVE_VIDEO_FLAG_OE] && !pdn_active;
         if (byte_tick) begin
            active_video_flag_o <= (phase == PH_ACTIVE);
            hsync_o <= !ctrl[`CTRL_EMBEDDED] && hsync_now;
            case (vs_mode)
               VS_SYNC: vsync_o <= in_vsync;
               VS_LINE_FLAG: vsync_o <= !line_inverted;
               VS_HLOCK: vsync_o <= h_lock_i;
               default: vsync_o <= 1'b0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------
   // Chroma serial output
   // ----------------------------------------------------------
   logic [23:0] chroma_shift; // Bits left to send
   logic [4:0] chroma_bits; // Bits sent of the current word
   logic [1:0] rtc_div; // Quarter-rate divider
   logic sclk_rise; // One output clock period elapsed
   logic chroma_step; // Shift one bit now
   assign sclk_rise = (ctrl[`CTRL_SCLK_2X] ? half_tick : byte_tick) && !sclk_o;
   assign chroma_step = sclk_rise && (!ctrl[`CTRL_CHROMA_RTC] || rtc_div == 2'b11);

   // Shift the colour loop word MSB first, reload after 24 bits
   always_ff @(posedge clk_i) begin
      if (soft_reset) begin
         chroma_shift <= 24'h00_0000;
         chroma_bits <= 5'd0;
         rtc_div <= 2'b00;
      end else if (ce_i) begin
         if (sclk_rise) begin
            rtc_div <= 2'(rtc_div + 2'b01);
         end
         if (chroma_step) begin
            if (chroma_bits == 5'd23) begin
               chroma_bits <= 5'd0;
               chroma_shift <= chroma_word;
            end else begin
               chroma_bits <= 5'(chroma_bits + 5'd1);
               chroma_shift <= {chroma_shift[22:0], 1'b0};
            end
         end
      end
   end

   // Shared field pin: field or vertical lock, or the serial stream
   always_ff @(posedge clk_i) begin
      if (soft_reset) begin
         field_pin_o <= 1'b0;
      end else if (ce_i) begin
         if (ctrl[`CTRL_PIN_CHROMA]) begin
            field_pin_o <= chroma_shift[23];
         end else begin
            field_pin_o <= ctrl[`CTRL_FIELD_VLOCK] ? v_lock_i : odd_field;
         end
      end
   end

   // ----------------------------------------------------------
   // General-purpose pin
   // ----------------------------------------------------------
   // Output level, blank marker, released as input, or interrupt
   always_ff @(posedge clk_i) begin
      if (soft_reset) begin
         general_purpose_pin_o <= 1'b0;
         general_purpose_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         general_purpose_pin_oe_o <= (gp_mode != GP_SYNC_LOCK);
         case (gp_mode)
            GP_OUTPUT: general_purpose_pin_o <= ctrl[`CTRL_GP_LEVEL];
            GP_VBLANK: general_purpose_pin_o <= in_vblank;
            GP_IRQ: general_purpose_pin_o <= irq_source_i;
            default: general_purpose_pin_o <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------
   // Blank-line data slicer
   // ----------------------------------------------------------
   logic [7:0] vbi_data; // Last byte with good parity
   logic [7:0] vbi_errors; // Bytes refused, saturating

   // Check odd parity of active bytes in blank lines
   always_ff @(posedge clk_i) begin
      if (soft_reset) begin
         vbi_data <= 8'h00;
         vbi_errors <= 8'h00;
      end else if (ce_i && byte_tick && in_vblank && phase == PH_ACTIVE) begin
         if (^video_in_i) begin
            vbi_data <= video_in_i;
         end else if (vbi_errors != 8'hFF) begin
            vbi_errors <= 8'(vbi_errors + 8'h01);
         end
      end
   end

   // ----------------------------------------------------------
   // Bus read and acknowledge
   // ----------------------------------------------------------
   // Answer one cycle after the request, zero for unmapped offsets
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= bus_hit;
         if (bus_hit && !wb_we_i) begin
            case (wb_adr_i)
               `REG_CTRL: wb_dat_o <= ctrl;
               `REG_VBLANK: wb_dat_o <= vblank_cfg;
               `REG_NCO: wb_dat_o <= {16'h0000, nco_inc};
               `REG_PICT0: wb_dat_o <= pict0;
               `REG_PICT1: wb_dat_o <= {24'h00_0000, pict1};
               `REG_STATUS: wb_dat_o <= {6'h00, vcount, 6'h00, pdn_active, force_nominal,
                                         serial_addr};
               `REG_VBI: wb_dat_o <= {16'h0000, vbi_errors, vbi_data};
               `REG_CHROMA: wb_dat_o <= {8'h00, chroma_word};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

endmodule
`default_nettype wire

/* File: video_pin_interface_chk.sv */
// Purpose: Port-level checker for the video pin interface.
// Assumes: One clock domain; rst_i synchronous, active high.
// Notes: Attached by bind, watches top-level ports only.
`timescale 1ns/1ps
`default_nettype none
module video_pin_interface_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic video_out_msb_oe_o,
   input wire logic hsync_o,
   input wire logic active_video_flag_o
);
   // ---------------------------------------------
   // Bus and pin timing properties
   // ---------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_no_idle_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
   a_rdata_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data outside ack");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !video_out_msb_oe_o)
      else $error("outputs active after reset");
   a_strap_undriven: assert property (disable iff (1'b0) rst_i ##1 !rst_i |=> !video_out_msb_oe_o)
      else $error("strap pin driven before latch");
   a_hsync_blank: assert property (hsync_o |-> !active_video_flag_o)
      else $error("hsync during active video");
   a_hsync_width: assert property ($rose(hsync_o) |-> hsync_o [*3])
      else $error("hsync pulse too short");
   a_active_video_flag_width: assert property ($rose(active_video_flag_o) |-> active_video_flag_o [*8])
      else $error("active flag too short");
   c_hsync: cover property ($rose(hsync_o));
   c_active_video_flag: cover property ($rose(active_video_flag_o));
   c_strap: cover property ($rose(video_out_msb_oe_o));
endmodule
bind video_pin_interface video_pin_interface_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .video_out_msb_oe_o(video_out_msb_oe_o), .hsync_o(hsync_o),
   .active_video_flag_o(active_video_flag_o));
`default_nettype wire

/* File: video_sink_model.sv */
// Purpose: Downstream receiver model watching the output byte stream.
// Assumes: One byte per rise of the output clock (2x mode).
// Notes: Also resolves the strap/MSB pin from its pull and enable.
`timescale 1ns/1ps
`default_nettype none
module video_sink_model (
   input wire logic clk_i,
   input wire logic sclk_i,
   input wire logic [6:0] bus_i,
   input wire logic msb_i,
   input wire logic msb_oe_i,
   input wire logic pull_i,
   output logic msb_pin_o,
   output logic [15:0] eav_cnt_o = 16'h0000,
   output logic [7:0] code_o
);
   logic sclk_d; // Output clock one cycle back
   logic [23:0] hist; // Last three bytes seen
   // Pin level: driven value, else the pull resistor
   assign msb_pin_o = msb_oe_i ? msb_i : pull_i;
   // Capture a byte per output clock rise and spot timing codes
   always_ff @(posedge clk_i) begin
      sclk_d <= sclk_i;
      if (sclk_i && !sclk_d) begin
         hist <= {hist[15:0], msb_pin_o, bus_i};
         if (hist == 24'hFF0000) begin
            eav_cnt_o <= eav_cnt_o + 16'h0001;
            code_o <= {msb_pin_o, bus_i};
         end
      end
   end
endmodule
`default_nettype wire

/* File: video_decoder_pin_interface_tb.sv */
// Purpose: Self-checking bench for the video decoder pin interface.
// Assumes: Small line geometry; inputs driven at clk_i rise.
// Notes: Registers reached over classic Wishbone single cycles.
`timescale 1ns/1ps
`default_nettype none
`include "video_pins_defines.svh"
module video_decoder_pin_interface_tb;
   logic clk_i, rst_i, ce, hlock, cyc, we, pdn_n, rst_n, pull, gp_drv, vlock, irq;
   logic [7:0] adr, vin;
   logic [3:0] sel;
   logic [31:0] dat, rdat, wb_dat_o;
   logic wb_ack_o, sclk, active_video_flag_flag, active_video_flag_oe, hs, vs, fp, gp_o, gp_oe, gp_pin, msb_o, msb_oe, msb_pin;
   logic [6:0] bus;
   logic [15:0] eav_cnt;
   logic [7:0] code;
   int failures = 0;
   int num_checks = 0;
   assign gp_pin = gp_oe ? gp_o : gp_drv;
   video_pin_interface #(.LINE_BYTES(40), .ACTIVE_BYTES(16), .FRAME_LINES(10), .VSYNC_LINES(1),
      .HSYNC_BYTES(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .video_in_i(vin), .h_lock_i(hlock),
      .v_lock_i(vlock), .irq_source_i(irq), .power_down_n_i(pdn_n), .reset_n_i(rst_n),
      .video_out_msb_i(msb_pin), .general_purpose_pin_i(gp_pin), .video_out_bus_o(bus),
      .video_out_msb_o(msb_o), .video_out_msb_oe_o(msb_oe), .sclk_o(sclk), .hsync_o(hs),
      .active_video_flag_o(active_video_flag_flag), .active_video_flag_oe_o(active_video_flag_oe), .vsync_o(vs),
      .field_pin_o(fp), .general_purpose_pin_o(gp_o), .general_purpose_pin_oe_o(gp_oe));
   video_sink_model u_sink (.clk_i(clk_i), .sclk_i(sclk), .bus_i(bus), .msb_i(msb_o),
      .msb_oe_i(msb_oe), .pull_i(pull), .msb_pin_o(msb_pin), .eav_cnt_o(eav_cnt), .code_o(code));
   // ---------------------------------------------
   // Clock, watchdog and shared tasks
   // ---------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      #300000;
      failures++;
      end_sim();
   end
   task automatic end_sim();
      if (failures == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic cycle; held until ack is sampled high
   task automatic bus_op(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rdat = wb_dat_o;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus_op(1'b0, a, 32'h0);
      chk(rdat & m, e);
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_strap(input logic p, input logic [7:0] a);
      pull <= p;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk({30'h0, msb_oe, active_video_flag_oe}, 32'h3);
      rd_chk(`REG_STATUS, 32'hFF, {24'h0, a});
   endtask
   task automatic t_regs();
      rd_chk(`REG_CTRL, 32'hFFFF_FFFF, `CTRL_RESET);
      rd_chk(`REG_VBLANK, 32'hFFFF_FFFF, `VBLANK_RESET);
      rd_chk(8'h20, 32'hFFFF_FFFF, 32'h0);
      bus_op(1'b1, `REG_PICT1, 32'h0000_005A);
      rd_chk(`REG_PICT1, 32'hFF, 32'h5A);
      @(negedge active_video_flag_flag);
      @(posedge clk_i);
      bus_op(1'b1, `REG_CTRL, 32'h1);
      rd_chk(`REG_CTRL, 32'hFFFF_FFFF, 32'h1);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd_chk(`REG_CTRL, 32'hFFFF_FFFF, `CTRL_RESET);
   endtask
   task automatic t_pdn();
      pdn_n <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk({30'h0, msb_oe, active_video_flag_oe}, 32'h0);
      bus_op(1'b1, `REG_PICT1, 32'h0000_00C3);
      rd_chk(`REG_PICT1, 32'hFF, 32'h00);
      rd_chk(`REG_STATUS, 32'h200, 32'h200);
      pdn_n <= 1'b1;
      repeat (5) @(posedge clk_i);
   endtask
   task automatic t_codes();
      logic [15:0] n;
      logic f, v, h;
      n = eav_cnt;
      wait (eav_cnt == n + 16'h0002);
      @(negedge clk_i);
      {f, v, h} = code[6:4];
      chk({24'h0, code}, {24'h0, 1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h});
      @(posedge clk_i);
   endtask
   task automatic t_gp();
      bus_op(1'b1, `REG_CTRL, 32'h0000_0106);
      repeat (3) @(posedge clk_i);
      chk({30'h0, gp_oe, gp_o}, 32'h3);
      irq <= 1'b1;
      bus_op(1'b1, `REG_CTRL, 32'h0000_00C6);
      repeat (3) @(posedge clk_i);
      chk({30'h0, gp_oe, gp_o}, 32'h3);
      gp_drv <= 1'b1;
      bus_op(1'b1, `REG_CTRL, 32'h0000_0086);
      repeat (8) @(posedge clk_i);
      chk({31'h0, gp_oe}, 32'h0);
      rd_chk(`REG_STATUS, 32'h100, 32'h100);
   endtask
   task automatic t_lines();
      logic a;
      vin <= 8'h07;
      bus_op(1'b1, `REG_CTRL, 32'h0000_0016);
      @(posedge active_video_flag_flag);
      @(negedge clk_i);
      a = vs;
      @(posedge hs);
      @(posedge active_video_flag_flag);
      @(negedge clk_i);
      chk({31'h0, vs}, {31'h0, ~a});
      @(posedge clk_i);
      rd_chk(`REG_VBI, 32'hFF, 32'h07);
   endtask
   task automatic t_field();
      bus_op(1'b1, `REG_CTRL, 32'h0000_002F);
      vlock <= 1'b1;
      hlock <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk({30'h0, fp, vs}, 32'h3);
      vlock <= 1'b0;
      hlock <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk({30'h0, fp, vs}, 32'h0);
   endtask
   initial begin
      rst_i = 1'b1;
      {ce, hlock, cyc, we, pdn_n, rst_n, pull, gp_drv, vlock, irq} = 10'h238;
      {sel, vin} = 12'hF81;
      adr = 8'h00;
      dat = 32'h0;
      @(posedge clk_i);
      t_strap(1'b1, `ADDR_STRAP_HIGH);
      t_regs();
      t_pdn();
      t_codes();
      t_gp();
      t_lines();
      t_field();
      t_strap(1'b0, `ADDR_STRAP_LOW);
      end_sim();
   end
endmodule
`default_nettype wire
